// ---- port_pkg.sv ----
// Purpose: Shared constants for the clocked buffered I/O port block
// Assumes: 32 pins, five ports of widths 1/4/8/16/32 rooted at pin 0
// Notes:   Byte offsets for the AHB-Lite register map live here
package port_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int NPORT   = 5;           // Ports 1,4,8,16,32 bits
   localparam int NCLK    = 6;           // Clock blocks per tile
   localparam int NPIN    = 32;          // Physical pins
   localparam int CNT_W   = 16;          // Port counter width
   localparam int DIV_W   = 16;          // Clock block divider width
   // -------------------------------------------------------------
   // Register map (byte offsets)
   // -------------------------------------------------------------
   localparam int PORT_SH   = 5;         // Port stride 0x20
   localparam logic [4:0] OFF_CTRL  = 5'h00;
   localparam logic [4:0] OFF_DATA  = 5'h04;
   localparam logic [4:0] OFF_COND  = 5'h08;
   localparam logic [4:0] OFF_TIME  = 5'h0C;
   localparam logic [4:0] OFF_COUNT = 5'h10;
   localparam logic [4:0] OFF_TSTMP = 5'h14;
   localparam logic [4:0] OFF_STAT  = 5'h18;
   localparam logic [11:0] CLK_BASE = 12'h100;  // Clock blocks, one word each
   localparam logic [11:0] LINK_REG = 12'h120;  // Link enable
   // -------------------------------------------------------------
   // Port control fields
   // -------------------------------------------------------------
   localparam int C_EN     = 0;
   localparam int C_OUT    = 1;
   localparam int C_OD     = 2;
   localparam int C_SER    = 3;
   localparam int C_STB    = 4;
   localparam int C_COND   = 5;          // Two bits: 0 none, 1 equal, 2 differ
   localparam int C_TIMED  = 7;
   localparam int C_CLK    = 8;          // Three bits: clock block select
   localparam int CTRL_W   = 11;
   localparam logic [1:0] COND_NONE = 2'h0;
   localparam logic [1:0] COND_EQ   = 2'h1;
   localparam logic [1:0] COND_NE   = 2'h2;
   // -------------------------------------------------------------
   // Clock block fields
   // -------------------------------------------------------------
   localparam int K_SRC   = 16;          // Source is the 1-bit port pin
   localparam int K_DIVEN = 17;          // Divide the source
   localparam int KCFG_W  = 18;
   // -------------------------------------------------------------
   // Pins shared with the serial link
   // -------------------------------------------------------------
   localparam logic [31:0] LINK_PINS = 32'hF000_0000;
   localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
endpackage

// ---- clocked_buffered_io_port.sv ----
// Purpose: Buffered clocked I/O ports with clock blocks behind AHB-Lite
// Assumes: Pins arrive asynchronously; pin 0 is the 1-bit port
// Notes:   Zero-wait-state slave; read data latched in address phase
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module clocked_buffered_io_port (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst,
   // AHB-Lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   // Pins
   input  wire logic [port_pkg::NPIN-1:0]   pinIn,
   output logic      [port_pkg::NPIN-1:0]   pinOut,
   output logic      [port_pkg::NPIN-1:0]   pinOe,
   // Strobes and events
   input  wire logic                        strobe_in,
   output logic      [port_pkg::NPORT-1:0]  strobe_out,
   output logic      [port_pkg::NPORT-1:0]  portEvent
);
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   // Nominal width of each port
   function automatic int portWidth(input int p);
      case (p)
         0:       portWidth = 1;
         1:       portWidth = 4;
         2:       portWidth = 8;
         3:       portWidth = 16;
         default: portWidth = 32;
      endcase
   endfunction
   // Pins a port covers, rooted at pin 0
   function automatic logic [31:0] portMask(input int p);
      portMask = (portWidth(p) == 32) ? 32'hFFFF_FFFF
                 : ((32'h0000_0001 << portWidth(p)) - 32'h0000_0001);
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   logic [port_pkg::CTRL_W-1:0] ctrlReg [port_pkg::NPORT];  // Port control
   logic [31:0]                 condReg [port_pkg::NPORT];  // Condition value
   logic [port_pkg::CNT_W-1:0]  timeReg [port_pkg::NPORT];  // Timed compare
   logic [port_pkg::CNT_W-1:0]  cntReg  [port_pkg::NPORT];  // Port counter
   logic [port_pkg::CNT_W-1:0]  tsReg   [port_pkg::NPORT];  // Timestamp
   logic [31:0]                 txReg   [port_pkg::NPORT];  // Out transfer
   logic [31:0]                 rxReg   [port_pkg::NPORT];  // In transfer
   logic [31:0]                 shReg   [port_pkg::NPORT];  // Serializer
   logic [5:0]                  shCnt   [port_pkg::NPORT];  // Chunks left
   logic [31:0]                 latReg  [port_pkg::NPORT];  // Pin value
   logic [port_pkg::NPORT-1:0]  txFull;                     // Tx word waiting
   logic [port_pkg::NPORT-1:0]  rxFull;                     // Rx word ready
   logic [port_pkg::KCFG_W-1:0] kcfgReg [port_pkg::NCLK];   // Clock cfg
   logic [port_pkg::DIV_W-1:0]  divCnt  [port_pkg::NCLK];   // Divider count
   logic [port_pkg::NCLK-1:0]   tick;                       // Block edges
   logic                        linkEn;                     // Link owns pins
   // Bus pipeline
   logic                        dpWr;                       // Write data phase
   logic [11:0]                 dpAddr;                     // Its address
   logic [31:0]                 rdReg;                      // Read data
   // Synchronised pins
   logic [31:0]                 pinS1, pinS2, pinS3, pinF;  // Pin filter
   logic                        stbS1, stbS2, stbS3, stbF;  // Strobe filter
   logic                        pin0Prev;                   // Edge detect

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   // Three stages; value accepted once stages two and three agree
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinS1 <= 32'h0000_0000;
         pinS2 <= 32'h0000_0000;
         pinS3 <= 32'h0000_0000;
         pinF  <= 32'h0000_0000;
         stbS1 <= 1'b0;
         stbS2 <= 1'b0;
         stbS3 <= 1'b0;
         stbF  <= 1'b0;
      end else begin
         pinS1 <= pinIn;
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         pinF  <= (pinF & (pinS2 ^ pinS3)) | (pinS3 & ~(pinS2 ^ pinS3));
         stbS1 <= strobe_in;
         stbS2 <= stbS1;
         stbS3 <= stbS2;
         if (stbS2 == stbS3) begin
            stbF <= stbS3;
         end
      end
   end

   // -------------------------------------------------------------
   // Clock blocks
   // -------------------------------------------------------------
   // Block 0 ticks every cycle of the reference; others divide
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin0Prev <= 1'b0;
         tick     <= '0;
         for (int k = 0; k < port_pkg::NCLK; k++) begin
            divCnt[k] <= '0;
         end
      end else begin
         pin0Prev <= pinF[0];
         tick[0]  <= 1'b1;
         for (int k = 1; k < port_pkg::NCLK; k++) begin
            // Source edge: 1-bit port rising edge or reference
            if (!kcfgReg[k][port_pkg::K_SRC] || (pinF[0] && !pin0Prev)) begin
               if (kcfgReg[k][port_pkg::K_DIVEN] &&
                   divCnt[k] < kcfgReg[k][port_pkg::DIV_W-1:0]) begin
                  divCnt[k] <= divCnt[k] + 16'h0001;
                  tick[k]   <= 1'b0;
               end else begin
                  divCnt[k] <= '0;
                  tick[k]   <= 1'b1;
               end
            end else begin
               tick[k] <= 1'b0;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------
   // Never stalls, so every port access takes one cycle
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdReg;

   // Read mux; reads are sampled in the address phase
   function automatic logic [31:0] readMux(input logic [11:0] a);
      int p;
      p = int'(a[7:port_pkg::PORT_SH]);
      readMux = port_pkg::RD_ZERO;
      if (a[11:8] == 4'h0 && p < port_pkg::NPORT) begin
         case (a[4:0])
            port_pkg::OFF_CTRL:  readMux = {21'h0, ctrlReg[p]};
            port_pkg::OFF_DATA:  readMux = rxReg[p];
            port_pkg::OFF_COND:  readMux = condReg[p];
            port_pkg::OFF_TIME:  readMux = {16'h0, timeReg[p]};
            port_pkg::OFF_COUNT: readMux = {16'h0, cntReg[p]};
            port_pkg::OFF_TSTMP: readMux = {16'h0, tsReg[p]};
            port_pkg::OFF_STAT:  readMux = {24'h0, 2'h0, shCnt[p]} |
                                           {30'h0, rxFull[p], txFull[p]};
            default:             readMux = port_pkg::RD_ZERO;
         endcase
      end else if (a >= port_pkg::CLK_BASE && a < port_pkg::LINK_REG
                   && a[1:0] == 2'h0 && int'(a[4:2]) < port_pkg::NCLK) begin
         readMux = {14'h0, kcfgReg[int'(a[4:2])]};
      end else if (a == port_pkg::LINK_REG) begin
         readMux = {31'h0, linkEn};
      end
   endfunction

   logic addrPh;                                             // Accepted transfer
   assign addrPh = hsel && htrans[1] && hready;

   // Address-phase capture and registered read data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dpWr   <= 1'b0;
         dpAddr <= 12'h000;
         rdReg  <= 32'h0000_0000;
      end else begin
         // Upper address bits must be clear, so the map does not alias
         dpWr   <= addrPh && hwrite && haddr[31:12] == 20'h0_0000;
         dpAddr <= haddr[11:0];
         if (addrPh && !hwrite) begin
            rdReg <= (haddr[31:12] == 20'h0_0000) ? readMux(haddr[11:0]) : port_pkg::RD_ZERO;
         end
      end
   end

   // Port index and hits for the write data phase; rx read hits in the address phase
   logic       wrPort;                                       // Port window hit
   int         wrIdx;                                        // Port index
   logic       rdData [port_pkg::NPORT];                     // Rx word consumed
   assign wrPort = dpWr && dpAddr[11:8] == 4'h0;
   assign wrIdx  = int'(dpAddr[7:port_pkg::PORT_SH]);
   always_comb begin
      for (int p = 0; p < port_pkg::NPORT; p++) begin
         rdData[p] = addrPh && !hwrite && haddr[31:8] == 24'h00_0000 &&
                     int'(haddr[7:port_pkg::PORT_SH]) == p &&
                     haddr[4:0] == port_pkg::OFF_DATA;
      end
   end

   // Clock block and link configuration writes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         linkEn <= 1'b0;
         for (int k = 0; k < port_pkg::NCLK; k++) begin
            kcfgReg[k] <= '0;
         end
      end else if (dpWr) begin
         if (dpAddr == port_pkg::LINK_REG) begin
            linkEn <= hwdata[0];
         end else if (dpAddr > port_pkg::CLK_BASE && dpAddr < port_pkg::LINK_REG
                      && dpAddr[1:0] == 2'h0 && int'(dpAddr[4:2]) < port_pkg::NCLK) begin
            // Block 0 stays fixed on the reference
            kcfgReg[int'(dpAddr[4:2])] <= hwdata[port_pkg::KCFG_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Port engines
   // -------------------------------------------------------------
   // One loop body per port: register writes, serializer, counter
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txFull     <= '0;
         rxFull     <= '0;
         strobe_out <= '0;
         portEvent  <= '0;
         for (int p = 0; p < port_pkg::NPORT; p++) begin
            ctrlReg[p] <= '0;
            condReg[p] <= '0;
            timeReg[p] <= '0;
            cntReg[p]  <= '0;
            tsReg[p]   <= '0;
            txReg[p]   <= '0;
            rxReg[p]   <= '0;
            shReg[p]   <= '0;
            shCnt[p]   <= '0;
            latReg[p]  <= '0;
         end
      end else begin
         for (int p = 0; p < port_pkg::NPORT; p++) begin
            logic        pTick, timeOk, condOk, stbOk, isSer, rxLoad;
            logic [31:0] inVal, nextSh;
            int          w, sel;
            w      = portWidth(p);
            sel    = int'(ctrlReg[p][port_pkg::C_CLK +: 3]);
            pTick  = (sel < port_pkg::NCLK) ? tick[sel] : tick[0];
            isSer  = ctrlReg[p][port_pkg::C_SER] && w < 32;
            inVal  = pinF & portMask(p);
            nextSh = (shReg[p] >> w) | (inVal << (32 - w));
            timeOk = !ctrlReg[p][port_pkg::C_TIMED] ||
                     cntReg[p] == timeReg[p] || shCnt[p] != 6'h00;
            case (ctrlReg[p][port_pkg::C_COND +: 2])
               port_pkg::COND_EQ: condOk = inVal == (condReg[p] & portMask(p));
               port_pkg::COND_NE: condOk = inVal != (condReg[p] & portMask(p));
               default:           condOk = 1'b1;
            endcase
            stbOk = !ctrlReg[p][port_pkg::C_STB] || stbF;
            // Input word lands this edge; it beats a software read
            rxLoad = pTick && ctrlReg[p][port_pkg::C_EN] && !ctrlReg[p][port_pkg::C_OUT] &&
                     timeOk && condOk && stbOk && (!isSer || shCnt[p] == 6'h01);
            strobe_out[p] <= 1'b0;
            portEvent[p]  <= 1'b0;

            // Counter advances once per block edge
            if (pTick) begin
               cntReg[p] <= cntReg[p] + 16'h0001;
            end

            if (pTick && ctrlReg[p][port_pkg::C_EN] && ctrlReg[p][port_pkg::C_OUT]) begin
               // Output direction: feed serializer chunks to the pins
               if (shCnt[p] != 6'h00) begin
                  latReg[p]     <= shReg[p] & portMask(p);
                  shReg[p]      <= shReg[p] >> w;
                  shCnt[p]      <= shCnt[p] - 6'h01;
                  strobe_out[p] <= 1'b1;
               end else if (txFull[p] && timeOk) begin
                  latReg[p]     <= txReg[p] & portMask(p);
                  shReg[p]      <= txReg[p] >> w;
                  shCnt[p]      <= isSer ? 6'(32 / w - 1) : 6'h00;
                  txFull[p]     <= 1'b0;
                  tsReg[p]      <= cntReg[p];
                  ctrlReg[p][port_pkg::C_TIMED] <= 1'b0;
                  strobe_out[p] <= 1'b1;
               end
            end else if (pTick && ctrlReg[p][port_pkg::C_EN] && timeOk && condOk && stbOk) begin
               // Input direction: sample pins into the serializer
               if (!isSer || shCnt[p] == 6'h01) begin
                  rxReg[p]  <= isSer ? nextSh : inVal;
                  rxFull[p] <= 1'b1;
                  shCnt[p]  <= 6'h00;
                  tsReg[p]  <= cntReg[p];
                  ctrlReg[p][port_pkg::C_TIMED] <= 1'b0;
               end else begin
                  shReg[p] <= nextSh;
                  shCnt[p] <= (shCnt[p] == 6'h00) ? 6'(32 / w - 1) : shCnt[p] - 6'h01;
               end
               // A met condition is reported straight away
               if (ctrlReg[p][port_pkg::C_COND +: 2] != port_pkg::COND_NONE) begin
                  portEvent[p] <= 1'b1;
               end
            end

            // Software consumes the rx word; a new word wins
            if (rdData[p] && !rxLoad) begin
               rxFull[p] <= 1'b0;
            end

            // Register writes from the bus
            if (wrPort && wrIdx == p) begin
               case (dpAddr[4:0])
                  port_pkg::OFF_CTRL: ctrlReg[p] <= hwdata[port_pkg::CTRL_W-1:0];
                  port_pkg::OFF_DATA: begin
                     txReg[p]  <= hwdata;
                     txFull[p] <= 1'b1;
                  end
                  port_pkg::OFF_COND: condReg[p] <= hwdata;
                  port_pkg::OFF_TIME: timeReg[p] <= hwdata[port_pkg::CNT_W-1:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Pin ownership and drive
   // -------------------------------------------------------------
   // Narrowest enabled port owns a pin; link overrides the top four pins
   logic [31:0] drvOut, drvOe;                               // Mux result
   always_comb begin
      drvOut = 32'h0000_0000;
      drvOe  = 32'h0000_0000;
      for (int i = 0; i < port_pkg::NPIN; i++) begin
         logic found;
         found = 1'b0;
         for (int p = 0; p < port_pkg::NPORT; p++) begin
            if (!found && ctrlReg[p][port_pkg::C_EN] &&
                (portMask(p) & (32'h0000_0001 << i)) != 32'h0000_0000) begin
               found = 1'b1;
               if (ctrlReg[p][port_pkg::C_OUT]) begin
                  if (ctrlReg[p][port_pkg::C_OD]) begin
                     drvOut[i] = 1'b0;
                     drvOe[i]  = !latReg[p][i];
                  end else begin
                     drvOut[i] = latReg[p][i];
                     drvOe[i]  = 1'b1;
                  end
               end
            end
         end
      end
      if (linkEn) begin
         drvOe  = drvOe & ~port_pkg::LINK_PINS;
         drvOut = drvOut & ~port_pkg::LINK_PINS;
      end
   end

   // Pin outputs registered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinOut <= 32'h0000_0000;
         pinOe  <= 32'h0000_0000;
      end else begin
         pinOut <= drvOut;
         pinOe  <= drvOe;
      end
   end
endmodule
`default_nettype wire

// ---- port_checker.sv ----
// Purpose: Concurrent checks on the port block's bus and pin ports
// Assumes: One clock domain; attached to the top module by bind
// Notes:   Link state and first write are tracked from observed bus traffic
`timescale 1ns/1ps
`default_nettype none
module port_checker (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Pins and strobes
   input wire logic [31:0] pinOut,
   input wire logic [31:0] pinOe,
   input wire logic [4:0]  strobe_out,
   input wire logic [4:0]  portEvent
);
   logic rdTake;      // Read address phase taken
   logic wrTake;      // Write address phase taken
   logic linkWr_reg;  // Data phase of a link write
   logic linkEn_reg;  // Link enable as software left it
   logic wrSeen_reg;  // Any write since reset
   assign rdTake = hsel && htrans[1] && hready && !hwrite;
   assign wrTake = hsel && htrans[1] && hready && hwrite;
   // Mirror of the link bit; hwdata is only valid one cycle after the address
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         linkWr_reg <= 1'b0;
         linkEn_reg <= 1'b0;
         wrSeen_reg <= 1'b0;
      end else begin
         linkWr_reg <= wrTake && haddr == 32'(port_pkg::LINK_REG);
         if (linkWr_reg) linkEn_reg <= hwdata[0];
         if (wrTake) wrSeen_reg <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence unmapRd_s;
      rdTake && haddr > 32'h0000_0120;
   endsequence
   sequence zeroData_s;
      hrdata == 32'h0000_0000;
   endsequence
   ready_always_a: assert property (hreadyout)
      else $error("wait state inserted");
   resp_okay_a: assert property (!hresp)
      else $error("error response seen");
   rdata_hold_a: assert property (!$past(rdTake) |-> $stable(hrdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (unmapRd_s |=> zeroData_s)
      else $error("unmapped read not zero");
   link_release_a: assert property (linkEn_reg && $past(linkEn_reg, 3) |-> pinOe[31:28] == 4'h0)
      else $error("link pins still driven");
   dir_excl_a: assert property ((strobe_out & portEvent) == 5'h00)
      else $error("port both input and output");
   idle_quiet_a: assert property (!wrSeen_reg |-> strobe_out == 5'h00 && pinOe == 32'h0)
      else $error("activity before any write");
   reset_clear_a: assert property ($fell(rst) |-> pinOe == 32'h0 && pinOut == 32'h0)
      else $error("pins not cleared by reset");
endmodule
bind clocked_buffered_io_port port_checker chk (.clk_sys, .rst, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pinOut, .pinOe, .strobe_out,
   .portEvent);
`default_nettype wire

// ---- pin_partner.sv ----
// Purpose: External hardware on the pins: resolves each pin's level
// Assumes: No pull resistors, so an undriven pin wanders every cycle
// Notes:   The block wins any contention with the bench's own drive
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   // Clock
   input wire logic         clk_sys,
   // Block side of the pins
   input wire logic [31:0]  pinOut,
   input wire logic [31:0]  pinOe,
   // Bench commands
   input wire logic [31:0]  extVal,
   input wire logic [31:0]  extEn,
   input wire logic         stbReq,
   // Levels back to the block
   output logic [31:0]      pinIn,
   output logic             strobe_in
);
   logic [31:0] float_reg = 32'h5A5A_5A5A;  // Floating pins, never a steady value
   always_ff @(posedge clk_sys) float_reg <= ~float_reg;
   // A released open-drain one floats rather than reading high
   assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
                | (~pinOe & ~extEn & float_reg);
   assign strobe_in = stbReq;
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the clocked buffered port block
// Assumes: Zero-wait AHB-Lite slave; pins resolved by the partner model
// Notes:   Expected pin state comes from a small ownership model below
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, stbReq = 1'b1;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, extVal = 32'h0, extEn = 32'h0, q;
   wire logic [31:0] hrdata, pinIn, pinOut, pinOe;
   wire logic        hreadyout, hresp, strobe_in;
   wire logic [4:0]  strobe_out, portEvent;
   int fail_count = 0, check_count = 0, evCnt = 0, stbCnt = 0, link = 0;
   int en[5], od[5];       // Model: output ports enabled, open drain
   int unsigned v[5];      // Model: last word written per port
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   clocked_buffered_io_port uut (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pinIn, .pinOut, .pinOe,
      .strobe_in, .strobe_out, .portEvent);
   pin_partner pp (.clk_sys, .pinOut, .pinOe, .extVal, .extEn, .stbReq, .pinIn, .strobe_in);
   // Pulse counters for the 1-bit port's events and the 8-bit port's strobe
   always @(posedge clk_sys) begin
      if (portEvent[0] === 1'b1) evCnt++;
      if (strobe_out[2] === 1'b1) stbCnt++;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One single transfer; read data taken at the data-phase edge
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // Narrowest enabled port owns a pin; link takes the top four
   function automatic void model(output logic [31:0] o, output logic [31:0] e);
      int w[5] = '{1, 4, 8, 16, 32};
      o = 32'h0;
      e = 32'h0;
      for (int p = 4; p >= 0; p--)
         for (int i = 0; i < w[p]; i++)
            if (en[p] != 0) begin
               o[i] = od[p] != 0 ? 1'b0 : v[p][i];
               e[i] = od[p] != 0 ? !v[p][i] : 1'b1;
            end
      if (link != 0) e[31:28] = 4'h0;
   endfunction
   // Wait a bounded time for the pins to settle, then compare
   task automatic pins(input string n);
      logic [31:0] o, e;
      model(o, e);
      for (int i = 0; i < 20 && !(pinOe === e && (pinOut & e) === (o & e)); i++) idle(1);
      chk({n, " oe"}, e, pinOe);
      chk({n, " out"}, o & e, pinOut & e);
      $display("test %s done", n);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      $display("unexpected watchdog expected done seen hang");
      report_and_stop;
   end
   initial begin
      int unsigned g, c0;
      void'($urandom(32'h2A4F062E));
      idle(5);
      rst <= 1'b0;
      idle(1);
      for (int p = 0; p < 5; p++) begin
         bus(1'b0, 32'(p * 32), 32'h0);
         chk("ctrl", 32'h0, q);
      end
      bus(1'b0, 32'h0000_0200, 32'h0);
      chk("unmapped", 32'h0, q);
      // Counter advances once per block-0 tick, read at any moment
      bus(1'b1, 32'h0, 32'h1);
      g = $urandom_range(9);
      bus(1'b0, 32'h10, 32'h0);
      c0 = q;
      idle(g);
      bus(1'b0, 32'h10, 32'h0);
      chk("count", 32'((c0 + 2 + g) & 32'h0000_FFFF), q);
      // Block 1 divides the reference by four; port 3 counts its ticks
      bus(1'b1, 32'h104, 32'h0002_0003);
      bus(1'b1, 32'h60, 32'h100);
      bus(1'b0, 32'h70, 32'h0);
      c0 = q;
      idle(38);
      bus(1'b0, 32'h70, 32'h0);
      chk("divcount", 32'h0000_000A, (q - c0) & 32'h0000_FFFF);
      // Plain input sample on the 1-bit port
      extEn <= 32'h1;
      extVal <= 32'h1;
      idle(10);
      bus(1'b0, 32'h18, 32'h0);
      chk("rxfull", 32'h1, (q >> 1) & 32'h1);
      bus(1'b0, 32'h04, 32'h0);
      chk("rxbit", 32'h1, q & 32'h1);
      // Conditional sample: no event while the pin differs
      extVal <= 32'h0;
      bus(1'b1, 32'h08, 32'h1);
      bus(1'b1, 32'h00, 32'h31);
      idle(10);
      evCnt = 0;
      idle(10);
      chk("noevent", 32'h0, 32'(evCnt));
      // Condition met but strobe low: still no sample
      extVal <= 32'h1;
      stbReq <= 1'b0;
      idle(10);
      evCnt = 0;
      idle(10);
      chk("gated", 32'h0, 32'(evCnt));
      stbReq <= 1'b1;
      idle(10);
      chk("event", 32'h1, 32'(evCnt > 0));
      bus(1'b1, 32'h00, 32'h0);
      extEn <= 32'h0;
      $display("test input done");
      // Outputs: precedence, open drain, full width, link
      en[2] = 1;
      v[2] = $urandom;
      bus(1'b1, 32'h40, 32'h3);
      bus(1'b1, 32'h44, v[2]);
      pins("p2");
      chk("strobe", 32'h1, 32'(stbCnt > 0));
      en[1] = 1;
      v[1] = $urandom;
      bus(1'b1, 32'h20, 32'h3);
      bus(1'b1, 32'h24, v[1]);
      pins("p1");
      od[1] = 1;
      v[1] = $urandom;
      bus(1'b1, 32'h20, 32'h7);
      bus(1'b1, 32'h24, v[1]);
      pins("od");
      en[4] = 1;
      v[4] = $urandom;
      bus(1'b1, 32'h80, 32'h3);
      bus(1'b1, 32'h84, v[4]);
      pins("p4");
      link = 1;
      bus(1'b1, 32'h120, 32'h1);
      pins("link");
      report_and_stop;
   end
endmodule
`default_nettype wire
